/* design/uoef_top.sv */
// top: usb otg and error sticky flags with apb slave and one interrupt
// Operation
// RULE1: id pin change sets otg bit 7
// RULE2: one ms timer expiry sets bit 6
// RULE3: new stable line state sets bit 5
// RULE4: wake activity sets bit 4
// RULE5: vbus below session end sets bit 3
// RULE6: session end input change sets bit 2
// RULE7: session valid input change sets bit 0
// RULE8: flags reset zero, write one clears
// RULE9: bit stuff error sets error bit 7
// RULE10: bad descriptor or buffer address sets 6
// RULE11: dma late or truncation sets 5
// RULE12: turnaround timeout sets error bit 4
// RULE13: partial byte data field sets 3
// RULE14: data crc16 failure sets bit 2
// RULE15: bit 1 crc5 device, sof host
// RULE16: unimplemented bits read as zero
// RULE17: pid complement failure sets bit 0
// RULE18: flags sticky, set beats clear
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uoef_top
  import uoef_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic id_pin,
  input wire logic [1:0] line_pins,
  input wire logic sess_end_in,
  input wire logic sess_vld_in,
  input wire logic vbus_low_in,
  input wire logic wake_event,
  input wire uoef_errs_s err_ev,
  output logic irq
);
  uoef_state_s st_ff, nxt_st;
  uoef_pins_s raw;
  logic [7:0] otg_set, err_set, otg_clr, err_clr;
  logic wr_acc, rd_acc;

  // decode one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign raw = '{id: id_pin, line: line_pins, sess_end: sess_end_in,
                 sess_vld: sess_vld_in, vbus_low: vbus_low_in};
  // a write lands at the edge where the master samples pready high
  assign wr_acc = psel && penable && pwrite && st_ff.pready;
  assign rd_acc = psel && penable && !pwrite && !st_ff.pready;

  // otg set events from synchronised pins, the ms timer and the unsynchronised wake input
  always_comb begin
    otg_set = 8'h00;
    otg_set[OTG_ID_BIT] = st_ff.s2.id != st_ff.prev.id; // RULE1
    otg_set[OTG_MS_BIT] = st_ff.ms_cnt == MS_CNT_MAX; // RULE2
    otg_set[OTG_LINE_BIT] = st_ff.line_armed && st_ff.line_cnt == MS_CNT_MAX
                            && st_ff.cand_line != st_ff.stable_line; // RULE3
    otg_set[OTG_ACT_BIT] = wake_event; // RULE4
    otg_set[OTG_SESV_BIT] = st_ff.s2.vbus_low && !st_ff.prev.vbus_low; // RULE5
    otg_set[OTG_SESE_BIT] = st_ff.s2.sess_end != st_ff.prev.sess_end; // RULE6
    otg_set[OTG_AVBUS_BIT] = st_ff.s2.sess_vld != st_ff.prev.sess_vld; // RULE7
  end

  // error set events, bit 1 chosen by role
  always_comb begin
    err_set = 8'h00;
    err_set[ERR_BTS_BIT] = err_ev.bit_stuff; // RULE9
    err_set[ERR_BMX_BIT] = err_ev.bdt_base_bad || err_ev.buf_addr_bad; // RULE10
    err_set[ERR_DMA_BIT] = err_ev.dma_late || err_ev.dma_trunc; // RULE11
    err_set[ERR_BTO_BIT] = err_ev.turnaround_to; // RULE12
    err_set[ERR_DFN_BIT] = err_ev.field_size; // RULE13
    err_set[ERR_CRC16_BIT] = err_ev.crc16; // RULE14
    err_set[ERR_CRC5_BIT] = st_ff.host_role ? err_ev.sof_zero_busy : err_ev.crc5; // RULE15
    err_set[ERR_PID_BIT] = err_ev.pid_check; // RULE17
  end

  // write-one-to-clear strobes from the status or clear registers
  always_comb begin
    otg_clr = 8'h00;
    err_clr = 8'h00;
    if (wr_acc && hit(paddr, OTG_STAT_OFF)) begin
      otg_clr = pwdata[7:0]; // RULE8
    end
    if (wr_acc && hit(paddr, ERR_STAT_OFF)) begin
      err_clr = pwdata[7:0]; // RULE8
    end
    if (wr_acc && hit(paddr, IRQ_CLR_OFF)) begin
      otg_clr = otg_clr | pwdata[7:0];
      err_clr = err_clr | pwdata[15:8];
    end
  end

  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.prev = st_ff.s2;
    // free running millisecond timer
    nxt_st.ms_cnt = (st_ff.ms_cnt == MS_CNT_MAX) ? 15'h0000 : st_ff.ms_cnt + 15'h0001;
    // line stability tracker
    if (st_ff.s2.line != st_ff.cand_line) begin
      nxt_st.cand_line = st_ff.s2.line;
      nxt_st.line_cnt = 15'h0000;
      nxt_st.line_armed = 1'b1;
    end else if (st_ff.line_armed) begin
      if (st_ff.line_cnt == MS_CNT_MAX) begin
        nxt_st.line_armed = 1'b0;
        nxt_st.stable_line = st_ff.cand_line; // RULE3
      end else begin
        nxt_st.line_cnt = st_ff.line_cnt + 15'h0001;
      end
    end
    // sticky flags, set wins over clear
    nxt_st.otg_flags = ((st_ff.otg_flags & ~otg_clr) | otg_set) & OTG_IMPL_MASK; // RULE18 RULE16
    nxt_st.err_flags = (st_ff.err_flags & ~err_clr) | err_set; // RULE18
    // register writes
    if (wr_acc && hit(paddr, IRQ_EN_OFF)) begin
      nxt_st.irq_en = pwdata[15:0];
    end
    if (wr_acc && hit(paddr, ROLE_OFF)) begin
      nxt_st.host_role = pwdata[0];
    end
    // apb answer, one wait state
    nxt_st.pready = (psel && penable && !st_ff.pready);
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata = 32'h0000_0000;
    if (psel && penable && !st_ff.pready) begin
      if (!(hit(paddr, OTG_STAT_OFF) || hit(paddr, ERR_STAT_OFF) || hit(paddr, IRQ_EN_OFF)
            || hit(paddr, IRQ_CLR_OFF) || hit(paddr, ROLE_OFF))) begin
        nxt_st.pslverr = 1'b1;
      end
    end
    if (rd_acc) begin
      unique case (1'b1)
        hit(paddr, OTG_STAT_OFF): nxt_st.prdata = {24'h000000, st_ff.otg_flags}; // RULE16
        hit(paddr, ERR_STAT_OFF): nxt_st.prdata = {24'h000000, st_ff.err_flags}; // RULE16
        hit(paddr, IRQ_EN_OFF): nxt_st.prdata = {16'h0000, st_ff.irq_en};
        hit(paddr, ROLE_OFF): nxt_st.prdata = {31'h00000000, st_ff.host_role};
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end
    nxt_st.irq = |({nxt_st.err_flags, nxt_st.otg_flags} & nxt_st.irq_en);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0; // RULE8
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign irq = st_ff.irq;

  // checks
  a_id_change_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (st_ff.s2.id != st_ff.prev.id) |=> st_ff.otg_flags[OTG_ID_BIT])
    else $error("id change did not set flag");
  a_ms_tick_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (st_ff.ms_cnt == MS_CNT_MAX) |=> st_ff.otg_flags[OTG_MS_BIT] && st_ff.ms_cnt == 15'h0000)
    else $error("ms timer flag missing");
  a_line_stable_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    otg_set[OTG_LINE_BIT] |=> st_ff.otg_flags[OTG_LINE_BIT]
      && st_ff.stable_line == $past(st_ff.cand_line))
    else $error("line stable flag missing");
  a_wake_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    wake_event |=> st_ff.otg_flags[OTG_ACT_BIT])
    else $error("activity flag missing");
  a_vbus_low_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    $rose(st_ff.s2.vbus_low) |=> st_ff.otg_flags[OTG_SESV_BIT])
    else $error("session valid flag missing");
  a_sess_end_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    $changed(st_ff.s2.sess_end) |=> st_ff.otg_flags[OTG_SESE_BIT])
    else $error("session end flag missing");
  a_sess_vld_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    $changed(st_ff.s2.sess_vld) |=> st_ff.otg_flags[OTG_AVBUS_BIT])
    else $error("a device vbus flag missing");
  a_clear_one: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (wr_acc && hit(paddr, ERR_STAT_OFF) && pwdata[ERR_PID_BIT] && !err_ev.pid_check)
      |=> !st_ff.err_flags[ERR_PID_BIT])
    else $error("write one did not clear");
  a_err_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (err_ev.bit_stuff || err_ev.dma_trunc || err_ev.crc16)
      |=> |(st_ff.err_flags & 8'ha4))
    else $error("error flag missing");
  a_role_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    (st_ff.host_role && err_ev.sof_zero_busy) |=> st_ff.err_flags[ERR_CRC5_BIT])
    else $error("host eof flag missing");
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    !st_ff.otg_flags[1])
    else $error("unimplemented bit set");
  a_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    (st_ff.err_flags[ERR_BMX_BIT] && err_clr[ERR_BMX_BIT] == 1'b0)
      |=> st_ff.err_flags[ERR_BMX_BIT])
    else $error("flag lost without clear");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    (err_ev.turnaround_to && err_clr[ERR_BTO_BIT]) |=> st_ff.err_flags[ERR_BTO_BIT])
    else $error("clear beat set");

  // each engine event lands in its error bit one edge later; crc5 only in device role, sof_zero_busy only in host role
  a_bmx_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (err_ev.bdt_base_bad || err_ev.buf_addr_bad) |=> st_ff.err_flags[ERR_BMX_BIT])
    else $error("bus matrix flag missing");
  a_dma_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (err_ev.dma_late || err_ev.dma_trunc) |=> st_ff.err_flags[ERR_DMA_BIT])
    else $error("dma flag missing");
  a_timeout_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    err_ev.turnaround_to |=> st_ff.err_flags[ERR_BTO_BIT])
    else $error("turnaround flag missing");
  a_size_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    err_ev.field_size |=> st_ff.err_flags[ERR_DFN_BIT])
    else $error("field size flag missing");
  a_crc16_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    err_ev.crc16 |=> st_ff.err_flags[ERR_CRC16_BIT])
    else $error("data crc flag missing");
  a_crc5_device: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    (!st_ff.host_role && err_ev.crc5) |=> st_ff.err_flags[ERR_CRC5_BIT])
    else $error("token crc flag missing");
  a_pid_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    err_ev.pid_check |=> st_ff.err_flags[ERR_PID_BIT])
    else $error("pid flag missing");

  // otg flags are sticky too: held while no clear strobe hits them
  a_otg_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    (st_ff.otg_flags[OTG_ID_BIT] && !otg_clr[OTG_ID_BIT]) |=> st_ff.otg_flags[OTG_ID_BIT])
    else $error("otg flag lost without clear");

  // irq is the registered or of enabled flags
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.irq == |({st_ff.err_flags, st_ff.otg_flags} & st_ff.irq_en))
    else $error("irq does not follow enabled flags");

  // apb access: one wait state, then a one-cycle ready pulse
  sequence s_access_wait;
    psel && penable && !st_ff.pready;
  endsequence
  sequence s_ready_pulse;
    st_ff.pready ##1 !st_ff.pready;
  endsequence
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_access_wait |=> s_ready_pulse)
    else $error("ready pulse not one cycle after access");
endmodule
`default_nettype wire

/* design/uoef_pkg.sv */
// package: register map, bit positions and carrier types for the usb event flag block
package uoef_pkg;
  // register byte offsets on apb
  localparam logic [7:0] OTG_STAT_OFF = 8'h00;
  localparam logic [7:0] ERR_STAT_OFF = 8'h04;
  localparam logic [7:0] IRQ_EN_OFF = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFF = 8'h0c;
  localparam logic [7:0] ROLE_OFF = 8'h10;
  // otg group bit positions
  localparam int OTG_ID_BIT = 7;
  localparam int OTG_MS_BIT = 6;
  localparam int OTG_LINE_BIT = 5;
  localparam int OTG_ACT_BIT = 4;
  localparam int OTG_SESV_BIT = 3;
  localparam int OTG_SESE_BIT = 2;
  localparam int OTG_AVBUS_BIT = 0;
  localparam logic [7:0] OTG_IMPL_MASK = 8'hfd;
  // error group bit positions
  localparam int ERR_BTS_BIT = 7;
  localparam int ERR_BMX_BIT = 6;
  localparam int ERR_DMA_BIT = 5;
  localparam int ERR_BTO_BIT = 4;
  localparam int ERR_DFN_BIT = 3;
  localparam int ERR_CRC16_BIT = 2;
  localparam int ERR_CRC5_BIT = 1;
  localparam int ERR_PID_BIT = 0;
  // reset values
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [15:0] EN_RST = 16'h0000;
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int MS_US = 1000;
  localparam int MS_CYC = CLK_HZ / 1000000 * MS_US;
  localparam logic [14:0] MS_CNT_MAX = 15'(MS_CYC - 1);
  // pin group after synchronisation
  typedef struct packed {
    logic id;
    logic [1:0] line;
    logic sess_end;
    logic sess_vld;
    logic vbus_low;
  } uoef_pins_s;
  // one-cycle packet/dma error events from the engine
  typedef struct packed {
    logic bit_stuff;
    logic bdt_base_bad;
    logic buf_addr_bad;
    logic dma_late;
    logic dma_trunc;
    logic turnaround_to;
    logic field_size;
    logic crc16;
    logic crc5;
    logic sof_zero_busy;
    logic pid_check;
  } uoef_errs_s;
  // whole state of the block
  typedef struct packed {
    uoef_pins_s s1;
    uoef_pins_s s2;
    uoef_pins_s prev;
    logic [1:0] stable_line;
    logic [1:0] cand_line;
    logic [14:0] line_cnt;
    logic line_armed;
    logic [14:0] ms_cnt;
    logic [7:0] otg_flags;
    logic [7:0] err_flags;
    logic [15:0] irq_en;
    logic host_role;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } uoef_state_s;
endpackage

/* sim/uoef_peer.sv */
// peer model: usb-side pin levels and one-cycle engine error pulses
`timescale 1ns/1ps
`default_nettype none
module uoef_peer
  import uoef_pkg::*;
(
  input wire logic pclk,
  output var logic id_pin,
  output var logic [1:0] line_pins,
  output var logic sess_end_in,
  output var logic sess_vld_in,
  output var logic vbus_low_in,
  output var logic wake_event,
  output var uoef_errs_s err_ev
);
  // idle: all pins low, no pulses, so reset sees no changes
  initial begin
    {id_pin, line_pins, sess_end_in, sess_vld_in, vbus_low_in, wake_event} = 7'h00;
    err_ev = '0;
  end
  // set pin levels just after an edge, optional one-cycle wake pulse
  task automatic drive(input logic [3:0] p, input logic [1:0] ln, input logic wk);
    @(posedge pclk);
    {id_pin, sess_end_in, sess_vld_in, vbus_low_in} <= p;
    line_pins <= ln;
    wake_event <= wk;
    @(posedge pclk);
    wake_event <= 1'b0;
  endtask
  // one-cycle pulse on error field i, field 0 is the first in the struct
  task automatic err_pulse(input int i);
    @(posedge pclk);
    err_ev <= uoef_errs_s'(11'h400 >> i);
    @(posedge pclk);
    err_ev <= '0;
  endtask
endmodule
`default_nettype wire

/* sim/uoef_top_test.sv */
// testbench: apb master, sticky flag, clear and interrupt scenarios
`timescale 1ns/1ps
`default_nettype none
module uoef_top_test;
  import uoef_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic id_pin, sess_end_in, sess_vld_in, vbus_low_in, wake_event;
  logic [1:0] line_pins;
  uoef_errs_s err_ev;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int samples_checked = 0;
  // otg reads ignore the free-running ms bit
  localparam logic [31:0] MSK = 32'hffffffbf;
  int eb[11] = '{ERR_BTS_BIT, ERR_BMX_BIT, ERR_BMX_BIT, ERR_DMA_BIT, ERR_DMA_BIT,
    ERR_BTO_BIT, ERR_DFN_BIT, ERR_CRC16_BIT, ERR_CRC5_BIT, ERR_CRC5_BIT, ERR_PID_BIT};
  // clock 25 MHz
  always #20 pclk = ~pclk;
  uoef_top i_uoef_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .id_pin(id_pin), .line_pins(line_pins), .sess_end_in(sess_end_in),
    .sess_vld_in(sess_vld_in), .vbus_low_in(vbus_low_in), .wake_event(wake_event),
    .err_ev(err_ev), .irq(irq));
  uoef_peer i_uoef_peer (.pclk(pclk), .id_pin(id_pin), .line_pins(line_pins),
    .sess_end_in(sess_end_in), .sess_vld_in(sess_vld_in), .vbus_low_in(vbus_low_in),
    .wake_event(wake_event), .err_ev(err_ev));
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // reset values and an unmapped address
  task automatic reset_scn();
    apb(0, OTG_STAT_OFF, 0); chk("otg_rst", 0, rd);
    apb(0, ERR_STAT_OFF, 0); chk("err_rst", 0, rd);
    apb(0, IRQ_EN_OFF, 0); chk("en_rst", 0, rd);
    apb(1, 8'h20, 32'hffff); chk("unmapped_err", 1, 32'(er));
    apb(0, 8'h20, 0); chk("unmapped_rd", 32'h1, {rd[30:0], er});
  endtask
  // pin change or wake pulse sets one otg flag, write one clears it
  task automatic otg_scn(input logic [3:0] p, input logic wk, input int b);
    i_uoef_peer.drive(p, 2'b00, wk);
    repeat (6) @(posedge pclk);
    apb(1, OTG_STAT_OFF, 32'h0);
    apb(0, OTG_STAT_OFF, 0); chk("otg_set", 32'(1) << b, rd & MSK);
    apb(1, OTG_STAT_OFF, 32'hff);
    apb(0, OTG_STAT_OFF, 0); chk("otg_clr", 0, rd & MSK);
  endtask
  // each engine error sets its flag, stays through a zero write
  task automatic err_scn(input int i);
    apb(1, ROLE_OFF, 32'(i == 9));
    i_uoef_peer.err_pulse(i);
    repeat (4) @(posedge pclk);
    apb(1, ERR_STAT_OFF, 0);
    apb(0, ERR_STAT_OFF, 0); chk("err_set", 32'(1) << eb[i], rd);
    apb(1, ERR_STAT_OFF, 32'hff);
    apb(0, ERR_STAT_OFF, 0); chk("err_clr", 0, rd);
  endtask
  // line stable after one ms and ms timer expiry, then no new line state
  task automatic timer_scn();
    i_uoef_peer.drive(4'hf, 2'b01, 1'b0);
    apb(1, OTG_STAT_OFF, 32'hff);
    repeat (25020) @(posedge pclk);
    apb(0, OTG_STAT_OFF, 0); chk("line_ms", 32'h60, rd);
    apb(1, OTG_STAT_OFF, 32'hff);
    repeat (25020) @(posedge pclk);
    apb(0, OTG_STAT_OFF, 0); chk("ms_only", 32'h40, rd);
  endtask
  // enabled flag drives irq, clear register drops it, mask holds it low
  task automatic irq_scn();
    apb(1, IRQ_EN_OFF, 32'h0100);
    i_uoef_peer.err_pulse(10);
    repeat (3) @(posedge pclk);
    chk("irq_on", 1, 32'(irq));
    apb(1, IRQ_CLR_OFF, 32'h0100);
    @(posedge pclk);
    chk("irq_off", 0, 32'(irq));
    apb(0, IRQ_CLR_OFF, 0); chk("clr_rd", 0, rd);
    apb(0, ERR_STAT_OFF, 0); chk("err_clr2", 0, rd);
    apb(1, IRQ_EN_OFF, 0);
    i_uoef_peer.err_pulse(10);
    repeat (3) @(posedge pclk);
    chk("irq_mask", 0, 32'(irq));
    apb(0, ERR_STAT_OFF, 0); chk("err_held", 32'h1, rd);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_scn();
    otg_scn(4'b1000, 1'b0, OTG_ID_BIT);
    otg_scn(4'b1100, 1'b0, OTG_SESE_BIT);
    otg_scn(4'b1110, 1'b0, OTG_AVBUS_BIT);
    otg_scn(4'b1111, 1'b0, OTG_SESV_BIT);
    otg_scn(4'b1111, 1'b1, OTG_ACT_BIT);
    for (int i = 0; i < 11; i++) err_scn(i);
    irq_scn();
    timer_scn();
    wrap_up();
  end
endmodule
`default_nettype wire
